// ### include/swa_pkg.sv
// package for the summed waveform averager: register map, field layout, types
package swa_pkg;

	localparam int SAMPLE_W = 8;
	localparam int POINT_W = 10;
	localparam int POINTS_MAX = 1024;
	localparam int SWEEP_W = 16;
	localparam int ACC_W = SAMPLE_W + SWEEP_W;
	localparam int SLOTS = 2;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ACQ_CFG = 8'h04;
	localparam logic [7:0] REG_SWEEP_LIMIT = 8'h08;
	localparam logic [7:0] REG_POINT_LIMIT = 8'h0C;
	localparam logic [7:0] REG_REC_LEN = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
	localparam logic [7:0] REG_SWEEP_CNT = 8'h20;
	localparam logic [7:0] REG_RD_INDEX = 8'h24;
	localparam logic [7:0] REG_RD_DATA = 8'h28;
	localparam logic [7:0] REG_RD_AVG = 8'h2C;
	localparam logic [7:0] SLOT_STRIDE = 8'h40;

	// ctrl field positions
	localparam int CTRL_TRACE_ON = 0;
	localparam int CTRL_EXPAND_ON = 1;
	localparam int CTRL_SINGLE = 2;
	localparam int CTRL_REJECT = 3;
	localparam int CTRL_DITHER = 4;
	localparam int CTRL_SRC_LSB = 8;

	// source codes; slot-to-slot sources may form a loop
	localparam logic [1:0] SRC_CHAN_A = 2'h0;
	localparam logic [1:0] SRC_CHAN_B = 2'h1;
	localparam logic [1:0] SRC_SLOT_E = 2'h2;
	localparam logic [1:0] SRC_SLOT_F = 2'h3;

	// interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_REJECT = 1;
	localparam int IRQ_LOOP = 2;
	localparam int IRQ_W = 3;

	localparam logic [SAMPLE_W-1:0] CODE_UNDER = 8'h00;
	localparam logic [SAMPLE_W-1:0] CODE_OVER = 8'hFF;
	localparam int DITHER_SPAN = 6;
	localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
	localparam logic [SWEEP_W-1:0] RESET_SWEEP_LIMIT = 16'h0001;
	localparam logic [POINT_W:0] RESET_POINT_LIMIT = 11'h200;
	localparam logic [15:0] RESET_REC_LEN = 16'h0200;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// classic wishbone request bundle
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} swa_wb_req_t;

	// one sample from acquisition memory
	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [1:0] chan;
		logic [SAMPLE_W-1:0] code;
	} swa_sample_t;

endpackage : swa_pkg

// ### design/swa_averager.sv
// summed waveform averager with two slots and a wishbone register file
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
module swa_averager
	import swa_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire swa_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire swa_sample_t sample_i,
	output logic signed [3:0] dither_o,
	output logic irq_o
);

	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ADD} swa_state_t;

	// saturated codes, decoded twice per sample
	function automatic logic swa_saturated(input logic [SAMPLE_W-1:0] code);
		swa_saturated = (code == CODE_OVER) || (code == CODE_UNDER);
	endfunction : swa_saturated

	// undo the dither on one code, clamped to the 8-bit range
	function automatic logic [SAMPLE_W-1:0] swa_undither(input logic [SAMPLE_W-1:0] code,
			input logic signed [3:0] off);
		logic signed [9:0] v;
		v = $signed({2'b00, code}) - 10'(off);
		if (v < 0) begin
			swa_undither = CODE_UNDER;
		end else if (v > 10'sd255) begin
			swa_undither = CODE_OVER;
		end else begin
			swa_undither = v[SAMPLE_W-1:0];
		end
	endfunction : swa_undither

	logic [31:0] ctrl [SLOTS];
	logic [31:0] acq_cfg [SLOTS];
	logic [SWEEP_W-1:0] sweep_limit [SLOTS];
	logic [POINT_W:0] point_limit [SLOTS];
	logic [15:0] rec_len;
	logic [IRQ_W-1:0] irq_stat [SLOTS];
	logic [IRQ_W-1:0] irq_mask [SLOTS];
	logic [SWEEP_W-1:0] sweep_cnt [SLOTS];
	logic [POINT_W-1:0] rd_index [SLOTS];
	logic [ACC_W-1:0] acc [SLOTS][POINTS_MAX];
	logic [ACC_W-1:0] stage [SLOTS][POINTS_MAX];
	swa_state_t state [SLOTS];
	logic [15:0] stride_cnt [SLOTS];
	logic [POINT_W:0] kept [SLOTS];
	logic bad [SLOTS];
	logic signed [3:0] dither_cur;
	logic [3:0] dither_step;

	// bus decode
	wire wb_go = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	wire wb_wr = wb_go && wb_req_i.we && (wb_req_i.sel == 4'hF);
	wire wb_sl = wb_req_i.adr[6];
	wire [7:0] wb_off = {2'b00, wb_req_i.adr[5:0]};
	wire wb_rd_irq = wb_go && !wb_req_i.we && (wb_off == REG_IRQ_STAT);

	// mutual slot sources make a loop; no slot may run then
	wire loop_hit = (ctrl[0][CTRL_SRC_LSB+:2] == SRC_SLOT_F) &&
		(ctrl[1][CTRL_SRC_LSB+:2] == SRC_SLOT_E);

	// read mux per slot
	logic [31:0] rd_word;
	always_comb begin
		rd_word = UNMAPPED_DATA;
		unique case (wb_off)
			REG_CTRL: rd_word = ctrl[wb_sl];
			REG_ACQ_CFG: rd_word = acq_cfg[wb_sl];
			REG_SWEEP_LIMIT: rd_word = 32'(sweep_limit[wb_sl]);
			REG_POINT_LIMIT: rd_word = 32'(point_limit[wb_sl]);
			REG_REC_LEN: rd_word = 32'(rec_len);
			REG_STATUS: rd_word = {28'h0, loop_hit, bad[wb_sl],
				sweep_cnt[wb_sl] >= sweep_limit[wb_sl], state[wb_sl] != ST_IDLE};
			REG_IRQ_STAT: rd_word = 32'(irq_stat[wb_sl]);
			REG_IRQ_MASK: rd_word = 32'(irq_mask[wb_sl]);
			REG_SWEEP_CNT: rd_word = 32'(sweep_cnt[wb_sl]);
			REG_RD_INDEX: rd_word = 32'(rd_index[wb_sl]);
			REG_RD_DATA: rd_word = 32'(acc[wb_sl][rd_index[wb_sl]]);
			REG_RD_AVG: rd_word = (sweep_cnt[wb_sl] == '0) ? 32'h0 :
				32'(acc[wb_sl][rd_index[wb_sl]] / sweep_cnt[wb_sl]);
			default: rd_word = UNMAPPED_DATA;
		endcase
	end

	// single-cycle ack; data registered with it
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_go;
			wb_dat_o <= wb_go ? rd_word : wb_dat_o;
		end
	end

	// shared record length from the time base setting
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rec_len <= RESET_REC_LEN;
		end else if (wb_wr && wb_off == REG_REC_LEN) begin
			rec_len <= wb_req_i.dat[15:0];
		end
	end

	// dither: symmetric sequence -6..+6, steps once per record, mean zero
	wire rec_end = sample_i.valid && sample_i.last;
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			dither_step <= 4'h0;
			dither_o <= 4'sh0;
		end else if (rec_end) begin
			dither_step <= (dither_step == 4'hC) ? 4'h0 : dither_step + 4'h1;
			dither_o <= (ctrl[0][CTRL_DITHER] || ctrl[1][CTRL_DITHER]) ?
				4'(signed'({1'b0, dither_step}) - 5'sd6) : 4'sh0;
		end
	end
	assign dither_cur = dither_o; // offset applied to the record now arriving

	// any masked status bit of either slot raises the registered interrupt line
	logic next_irq;
	always_comb begin
		next_irq = 1'b0;
		for (int k = 0; k < SLOTS; k++) begin
			next_irq = next_irq | (|(irq_stat[k] & irq_mask[k]));
		end
	end
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end

	// one engine per slot
	for (genvar s = 0; s < SLOTS; s++) begin : g_slot
		wire [1:0] src = ctrl[s][CTRL_SRC_LSB+:2];
		wire sel_hit = wb_sl == 1'(s);
		wire wr_ctrl = wb_wr && sel_hit && wb_off == REG_CTRL;
		wire wr_acq = wb_wr && sel_hit && wb_off == REG_ACQ_CFG;
		wire wr_lim = wb_wr && sel_hit && wb_off == REG_SWEEP_LIMIT;
		wire wr_pts = wb_wr && sel_hit && wb_off == REG_POINT_LIMIT;
		wire wr_rec = wb_wr && wb_off == REG_REC_LEN;
		// a limit not below the count, or a ctrl write keeping the source, keeps the sum; acq or source changes and any point limit or record length write restart
		wire restart = (wr_acq && wb_req_i.dat != acq_cfg[s]) || wr_pts || wr_rec ||
			(wr_ctrl && wb_req_i.dat[CTRL_SRC_LSB+:2] != src) ||
			(wr_lim && wb_req_i.dat[SWEEP_W-1:0] < sweep_cnt[s]);
		wire enabled = (ctrl[s][CTRL_TRACE_ON] || ctrl[s][CTRL_EXPAND_ON]) &&
			!ctrl[s][CTRL_SINGLE] && !loop_hit;
		wire room = sweep_cnt[s] < sweep_limit[s];
		wire src_ok = src == SRC_CHAN_A || src == SRC_CHAN_B;
		wire hit = sample_i.valid && src_ok && sample_i.chan == {1'b0, src[0]};
		// stride N = ceil(record length / point limit), at least one
		wire [15:0] stride = (point_limit[s] == '0 || 16'(point_limit[s]) >= rec_len) ?
			16'h1 : 16'((rec_len + 16'(point_limit[s]) - 16'h1) / 16'(point_limit[s]));
		wire keep = sample_i.first || stride_cnt[s] == 16'h0;
		wire [SAMPLE_W-1:0] code = swa_undither(sample_i.code,
			ctrl[s][CTRL_DITHER] ? dither_cur : 4'sh0);
		wire sat = swa_saturated(sample_i.code);
		wire rec_done = hit && sample_i.last;
		wire reject = ctrl[s][CTRL_REJECT] && (bad[s] || (keep && sat));
		wire accept = rec_done && !reject && state[s] == ST_ADD;
		wire rd_irq_me = wb_rd_irq && sel_hit;
		logic [IRQ_W-1:0] ev;
		// a loop leaves no slot with a usable source, so any record end warns
		assign ev = {loop_hit && rec_end,
			rec_done && reject && state[s] == ST_ADD,
			accept && sweep_cnt[s] + 16'h1 == sweep_limit[s]};

		// configuration registers
		always_ff @(posedge core_clk_i or posedge reset_i) begin
			if (reset_i) begin
				ctrl[s] <= RESET_CTRL;
				acq_cfg[s] <= 32'h0;
				sweep_limit[s] <= RESET_SWEEP_LIMIT;
				point_limit[s] <= RESET_POINT_LIMIT;
				irq_mask[s] <= '0;
				rd_index[s] <= '0;
			end else begin
				if (wr_ctrl) ctrl[s] <= wb_req_i.dat;
				if (wr_acq) acq_cfg[s] <= wb_req_i.dat;
				if (wr_lim) sweep_limit[s] <= wb_req_i.dat[SWEEP_W-1:0];
				if (wr_pts) point_limit[s] <= wb_req_i.dat[POINT_W:0];
				if (wb_wr && sel_hit && wb_off == REG_IRQ_MASK) irq_mask[s] <= wb_req_i.dat[IRQ_W-1:0];
				if (wb_wr && sel_hit && wb_off == REG_RD_INDEX) rd_index[s] <= wb_req_i.dat[POINT_W-1:0];
			end
		end

		// sticky status; a new event wins over the read clear
		always_ff @(posedge core_clk_i or posedge reset_i) begin
			if (reset_i) begin
				irq_stat[s] <= '0;
			end else begin
				irq_stat[s] <= (rd_irq_me ? '0 : irq_stat[s]) | ev;
			end
		end

		// record sequencer: a record is staged then committed whole at its end
		always_ff @(posedge core_clk_i or posedge reset_i) begin
			if (reset_i) begin
				state[s] <= ST_IDLE;
				stride_cnt[s] <= '0;
				kept[s] <= '0;
				bad[s] <= 1'b0;
				sweep_cnt[s] <= '0;
			end else if (restart) begin
				state[s] <= ST_IDLE;
				sweep_cnt[s] <= '0;
				bad[s] <= 1'b0;
			end else if (hit) begin
				if (sample_i.first) begin
					state[s] <= (enabled && room) ? ST_ADD : ST_CHECK;
					kept[s] <= '0;
					bad[s] <= 1'b0;
				end
				stride_cnt[s] <= (keep && stride != 16'h1) ? 16'(stride - 16'h1) :
					(keep ? 16'h0 : 16'(stride_cnt[s] - 16'h1));
				if (keep && !sample_i.first) kept[s] <= kept[s] + 1'b1;
				if (keep && sat) bad[s] <= 1'b1;
				if (accept) sweep_cnt[s] <= sweep_cnt[s] + 16'h1;
				if (sample_i.last) state[s] <= ST_IDLE;
			end
		end

		// point store; partial sums only land when the record is accepted
		wire [POINT_W:0] idx = sample_i.first ? '0 : kept[s] + 1'b1;
		wire in_range = idx < point_limit[s] && idx < (POINT_W+1)'(POINTS_MAX);
		always_ff @(posedge core_clk_i) begin
			if (hit && keep && in_range) begin
				stage[s][idx[POINT_W-1:0]] <= (sweep_cnt[s] == '0 ? '0 :
					acc[s][idx[POINT_W-1:0]]) + ACC_W'(code);
			end
		end

		// commit: copy staged sums; cleared sum when the count is zero
		always_ff @(posedge core_clk_i) begin
			for (int p = 0; p < POINTS_MAX; p++) begin
				if (accept && p <= int'(idx) && p < int'(point_limit[s])) begin
					acc[s][p] <= (p == int'(idx) && keep) ? (sweep_cnt[s] == '0 ? '0 :
						acc[s][p]) + ACC_W'(code) : stage[s][p];
				end
			end
		end
	end

endmodule : swa_averager

// ### tb/swa_averager_properties.sv
// port-level checks for the averager, bound to the design
module swa_averager_properties
	import swa_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire swa_wb_req_t wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire swa_sample_t sample_i,
	input wire logic signed [3:0] dither_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// named causes; a record end or any bus cycle may move irq or dither
	wire logic req_new = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	wire logic rec_end = sample_i.valid && sample_i.last;
	wire logic ev = rec_end || wb_req_i.cyc;
	wire logic unmapped = !wb_req_i.we && (wb_req_i.adr[5:0] >= 6'h30);
	ack_timing_a: assert property (req_new |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(req_new))
		else $error("ack without request");
	unmapped_zero_a: assert property (req_new && unmapped |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	dat_hold_a: assert property (!wb_req_i.stb && !wb_ack_o |=> $stable(wb_dat_o))
		else $error("read data moved while idle");
	dither_range_a: assert property (dither_o >= -4'sh6 && dither_o <= 4'sh6)
		else $error("dither beyond six steps");
	dither_step_a: assert property ($changed(dither_o) |-> $past(ev) || $past(ev, 2))
		else $error("dither changed inside a record");
	irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_req_i.cyc) || $past(wb_req_i.cyc, 2)
		|| $past(wb_req_i.cyc, 3))
		else $error("irq dropped with no bus access");
	irq_rise_a: assert property ($rose(irq_o) |-> $past(ev) || $past(ev, 2) || $past(ev, 3)
		|| $past(ev, 4))
		else $error("irq rose with no event");
endmodule : swa_averager_properties

bind swa_averager swa_averager_properties swa_averager_properties_i (.core_clk_i(core_clk_i),
	.reset_i(reset_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sample_i(sample_i), .dither_o(dither_o), .irq_o(irq_o));

// ### tb/swa_acq_model.sv
// acquisition memory model: one record of dithered 8-bit codes per call
module swa_acq_model
	import swa_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic signed [3:0] dither_i,
	output swa_sample_t sample_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial sample_o = '0;
	// eight points, ramp from base; line scrambled between records so stale codes never pass
	task automatic send(input logic [7:0] base, input logic sat);
		logic signed [3:0] d;
		logic [7:0] c;
		d = dither_i;
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk_i);
			c = base + 8'(i) + 8'(d);
			if (sat && i == 4) c = CODE_OVER;
			sample_o <= '{valid: 1'b1, first: i == 0, last: i == 7, chan: SRC_CHAN_A, code: c};
		end
		@(posedge core_clk_i);
		sample_o <= '{valid: 1'b0, first: 1'b0, last: 1'b0, chan: 2'h0, code: ~c};
	endtask : send
endmodule : swa_acq_model

// ### tb/swa_averager_tb_top.sv
// self-checking bench for the summed waveform averager
module swa_averager_tb_top
	import swa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	swa_wb_req_t wb_req = '0;
	swa_sample_t sample;
	logic [31:0] wb_dat;
	logic wb_ack;
	logic irq;
	logic signed [3:0] dither;
	int num_errors = 0;
	int n_tests = 0;
	// 10 MHz system clock
	always #50 core_clk_i = ~core_clk_i;
	swa_averager swa_averager_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_req_i(wb_req),
		.wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .sample_i(sample), .dither_o(dither), .irq_o(irq));
	swa_acq_model swa_acq_model_i (.core_clk_i(core_clk_i), .dither_i(dither), .sample_o(sample));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one classic cycle; a dead slave is left to the watchdog
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge core_clk_i);
		end while (wb_ack !== 1'b1);
		q = wb_dat;
		wb_req <= '0;
		@(posedge core_clk_i);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, q & m, exp);
	endtask : rdchk
	task automatic cnt(input logic [31:0] exp);
		rdchk("sweep_cnt", REG_SWEEP_CNT, 32'hFFFF, exp);
	endtask : cnt
	// commit lands at the last sample; allow it to show before reading
	task automatic rec(input logic [7:0] base, input logic sat);
		swa_acq_model_i.send(base, sat);
		repeat (3) @(posedge core_clk_i);
	endtask : rec
	task automatic t_reset();
		rdchk("sweep_limit", REG_SWEEP_LIMIT, 32'hFFFF, 32'h1);
		rdchk("point_limit", REG_POINT_LIMIT, 32'h7FF, 32'h200);
		cnt(32'h0);
		rdchk("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
		$display("reset test done");
	endtask : t_reset
	// stride 2 over 8 points, limit 3, one surplus record
	task automatic t_avg();
		logic x;
		wr(REG_REC_LEN, 32'h8);
		wr(REG_POINT_LIMIT, 32'h4);
		wr(REG_SWEEP_LIMIT, 32'h3);
		wr(REG_CTRL, 32'h1);
		repeat (4) rec(8'h0A, 1'b0);
		cnt(32'h3);
		for (int k = 0; k < 4; k++) begin
			wr(REG_RD_INDEX, 32'(k));
			rdchk("sum", REG_RD_DATA, 32'hFFFFFFFF, 32'(3 * (10 + 2 * k)));
		end
		rdchk("average", REG_RD_AVG, 32'hFF, 32'h10);
		wr(REG_IRQ_MASK, 32'h7);
		x = irq;
		wr(REG_IRQ_MASK, 32'h0);
		chk("irq_mask", 32'(x ^ irq), 32'h1);
		rdchk("irq_stat", REG_IRQ_STAT, 32'h7, 32'h1);
		wr(REG_IRQ_MASK, 32'h1);
		repeat (2) @(posedge core_clk_i);
		chk("irq_clear", 32'(irq), 32'h0);
		wr(REG_IRQ_MASK, 32'h0);
		$display("average test done");
	endtask : t_avg
	task automatic t_resume();
		wr(REG_SWEEP_LIMIT, 32'h4);
		rec(8'h0A, 1'b0);
		cnt(32'h4);
		wr(REG_ACQ_CFG, 32'h5);
		cnt(32'h0);
		rdchk("average", REG_RD_AVG, 32'hFF, 32'h0);
		wr(REG_CTRL, 32'h5);
		rec(8'h0A, 1'b0);
		cnt(32'h0);
		wr(REG_CTRL, 32'h0);
		rec(8'h0A, 1'b0);
		cnt(32'h0);
		wr(REG_CTRL, 32'h9);
		rec(8'h0A, 1'b1);
		cnt(32'h0);
		rdchk("irq_stat", REG_IRQ_STAT, 32'h2, 32'h2);
		wr(REG_CTRL, 32'h1);
		rec(8'h0A, 1'b1);
		cnt(32'h1);
		$display("pause and reject test done");
	endtask : t_resume
	// dither on: sums must match an undithered ramp; then a slot loop halts work
	task automatic t_dither();
		wr(REG_ACQ_CFG, 32'h6);
		wr(REG_CTRL, 32'h11);
		repeat (2) rec(8'h32, 1'b0);
		wr(REG_RD_INDEX, 32'h1);
		rdchk("dither_sum", REG_RD_DATA, 32'hFFFFFFFF, 32'h68);
		wr(REG_CTRL, 32'h301);
		wr(SLOT_STRIDE | REG_CTRL, 32'h201);
		rdchk("loop", REG_STATUS, 32'h8, 32'h8);
		rec(8'h32, 1'b0);
		cnt(32'h0);
		rdchk("loop_irq", REG_IRQ_STAT, 32'h4, 32'h4);
		$display("dither and loop test done");
	endtask : t_dither
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		repeat (3) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_avg();
		t_resume();
		t_dither();
		give_verdict();
	end
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge core_clk_i);
		num_errors++;
		give_verdict();
	end
endmodule : swa_averager_tb_top
